// [hw/macphy_cfg_pkg.sv]
package macphy_cfg_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [7:0]  ADDR_CAPABILITY  = 8'h02;
	localparam logic [7:0]  ADDR_RESET_CTRL  = 8'h03;
	localparam logic [7:0]  ADDR_MACPHY_CONFIGURATION_0     = 8'h04;

	localparam logic [31:0] CAPABILITY_VALUE = 32'h000006C3;
	localparam int          MIN_CHUNK_LSB    = 0;
	localparam logic [2:0]  MIN_CHUNK_EXP    = 3'h3;

	localparam int          SOFT_RESET_BIT   = 0;

	localparam int          CFG_SYNC_BIT     = 15;
	localparam logic [15:0] CFG0_RESET       = 16'h0006;
	// Plain read/write bits of configuration 0; bit 5 is a pin strap
	// that is not held here and bit 15 is write-one-to-set.
	localparam logic [15:0] CFG0_WMASK       = 16'h7FDF;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS  = 40;
	localparam int CS_MIN_HOLD_NS = 100;
	localparam int CS_MIN_HOLD_CYC =
		(CS_MIN_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ****************************************************************
	// Credit thresholds
	// ****************************************************************
	localparam int          CREDIT_W   = 6;
	localparam logic [5:0]  CREDITS_00 = 6'h01;
	localparam logic [5:0]  CREDITS_01 = 6'h04;
	localparam logic [5:0]  CREDITS_10 = 6'h08;
	localparam logic [5:0]  CREDITS_11 = 6'h10;

	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef struct packed {
		logic       sync;
		logic       tx_fcs_check_enable;
		logic       chip_select_rx_align_enable;
		logic       zero_offset_rx_align_enable;
		logic [1:0] tx_credit_irq_threshold;
		logic [9:0] low_bits;
	} cfg_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] data;
	} reg_resp_t;

endpackage

// [hw/rx_tx_policy.sv]
`timescale 1ns/10ps
module rx_tx_policy
	import macphy_cfg_pkg::*;
(
	input  wire logic                clk_sys,          // System clock.
	input  wire logic                rst,              // Internal reset.
	input  wire logic                oa_mode,          // Chunked protocol.
	input  wire cfg_t                cfg,              // Configuration 0.
	input  wire logic [CREDIT_W-1:0] tx_free_credits,  // Free credits.
	input  wire logic [3:0]          start_word_offset, // Proposed offset.
	input  wire logic                first_after_cs,   // First chunk.
	output logic                     credit_irq,       // Threshold met.
	output logic                     rx_start_allowed  // Frame may start.
);

	// ****************************************************************
	// Decoding
	// ****************************************************************
	function automatic logic [CREDIT_W-1:0] credit_need(
		input logic [1:0] code);
		unique case (code)
			2'b00: credit_need = CREDITS_00;
			2'b01: credit_need = CREDITS_01;
			2'b10: credit_need = CREDITS_10;
			2'b11: credit_need = CREDITS_11;
		endcase
	endfunction

	logic next_credit_irq;
	logic next_rx_start_allowed;
	logic offset_zero;

	always_comb begin
		offset_zero = (start_word_offset == 4'h0);
		// The generic protocol has no chunks, so none of these apply.
		next_credit_irq = oa_mode && (tx_free_credits >=
			credit_need(cfg.tx_credit_irq_threshold));
		next_rx_start_allowed = 1'b1;
		if (oa_mode) begin
			if (cfg.chip_select_rx_align_enable) begin
				next_rx_start_allowed = first_after_cs && offset_zero;
			end else if (cfg.zero_offset_rx_align_enable) begin
				next_rx_start_allowed = offset_zero;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			credit_irq       <= 1'b0;
			rx_start_allowed <= 1'b1;
		end else begin
			credit_irq       <= next_credit_irq;
			rx_start_allowed <= next_rx_start_allowed;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	a_credit_thresh: assert property (oa_mode && tx_free_credits >= 6'h08
		&& cfg.tx_credit_irq_threshold == 2'b10 |=> credit_irq)
		else $error("credit interrupt missing at threshold");
	a_credit_below: assert property (tx_free_credits < 6'h04
		&& cfg.tx_credit_irq_threshold == 2'b01 |=> !credit_irq)
		else $error("credit interrupt below threshold");
	a_generic_gate: assert property (!oa_mode |=> rx_start_allowed
		&& !credit_irq)
		else $error("chunk features active in generic mode");
	a_cs_align: assert property (oa_mode
		&& cfg.chip_select_rx_align_enable && !first_after_cs
		|=> !rx_start_allowed)
		else $error("frame start outside first chunk");
	c_credit_irq: cover property (!credit_irq ##1 credit_irq);

endmodule

// [hw/macphy_cfg_regs.sv]
`timescale 1ns/10ps
// Functional notes
// - Read-only field [2:0] reports minimum chunk exponent, reset value 3.
// - Writing one to reset bit 0 resets all state and registers; the pin synchronisers are not reset.
// - Software reset waits until chip select is deasserted.
// - Reset request bit clears itself once the reset is done.
// - Configuration-done flag feeds every receive footer sync bit.
// - Configuration-done flag sets on write of one, only reset clears.
// - After any reset: flag clear, reset-complete set, interrupt asserted.
// - Transmit FCS check enable makes last four octets get checked.
// - Chip-select alignment: frames start only in first chunk after CS.
// - Zero alignment: frames start only at payload offset zero.
// - Credit interrupt only when free credits reach the selected threshold.
// - Alignment, threshold and chunk features only in chunked protocol.
module macphy_cfg_regs
	import macphy_cfg_pkg::*;
(
	input  wire logic                clk_sys,           // System clock.
	input  wire logic                reset,             // Power-on reset.
	input  wire logic                cs_n_pin,          // Chip select pin.
	input  wire logic                oa_mode_pin,       // Protocol strap.
	input  wire reg_req_t            req,               // Register access.
	input  wire logic                reset_complete_clear, // Status clear.
	input  wire logic [CREDIT_W-1:0] tx_free_credits,   // Free credits.
	input  wire logic [3:0]          start_word_offset, // Proposed offset.
	input  wire logic                rx_chunk_first_after_cs, // First chunk.
	output reg_resp_t                resp,              // Read answer.
	output logic                     soft_reset_out,    // Device-wide reset.
	output logic                     irq_n,             // Interrupt pin.
	output logic                     reset_complete_flag, // Status flag.
	output logic                     rx_footer_sync,    // Footer sync bit.
	output logic                     tx_fcs_check_enable, // FCS checker on.
	output logic                     rx_start_allowed,  // Frame may start.
	output logic [2:0]               min_chunk_payload_exp // Capability.
);

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic cs_n_meta;
	logic cs_idle;
	logic mode_meta;
	logic oa_mode;

	// These run through reset on purpose, so the pins have settled by
	// the time reset lifts and the mode-gated outputs start correct.
	// A reset value here would force generic mode for two cycles.
	always_ff @(posedge clk_sys) begin
		cs_n_meta <= cs_n_pin;
		cs_idle   <= cs_n_meta;
		mode_meta <= oa_mode_pin;
		oa_mode   <= mode_meta;
	end

	// ****************************************************************
	// Address decode
	// ****************************************************************
	typedef enum logic [3:0] {
		SEL_NONE  = 4'b0001,
		SEL_CAP   = 4'b0010,
		SEL_RESET = 4'b0100,
		SEL_CFG0  = 4'b1000
	} reg_sel_t;

	function automatic reg_sel_t reg_select(input logic [7:0] addr);
		if (addr == ADDR_CAPABILITY) begin
			reg_select = SEL_CAP;
		end else if (addr == ADDR_RESET_CTRL) begin
			reg_select = SEL_RESET;
		end else if (addr == ADDR_MACPHY_CONFIGURATION_0) begin
			reg_select = SEL_CFG0;
		end else begin
			reg_select = SEL_NONE;
		end
	endfunction

	// ****************************************************************
	// Software reset and configuration state
	// ****************************************************************
	// The internal reset covers one cycle after the request fires, so
	// every register here except the pin synchronisers, and downstream, sees its default together.
	logic rst_int;
	logic soft_reset_pending;
	logic next_soft_reset_pending;
	logic next_soft_reset_out;
	cfg_t cfg;
	cfg_t next_cfg;
	logic next_reset_complete;
	logic credit_irq;
	logic next_irq_n;

	assign rst_int = reset | soft_reset_out;

	always_comb begin
		next_soft_reset_pending = soft_reset_pending;
		if (req.wr && reg_select(req.addr) == SEL_RESET
			&& req.wdata[SOFT_RESET_BIT]) begin
			next_soft_reset_pending = 1'b1;
		end
		// The command that set the bit is still running while chip
		// select is low; firing early would cut off its own write.
		next_soft_reset_out = soft_reset_pending && cs_idle
			&& !soft_reset_out;

		next_cfg = cfg;
		if (req.wr && reg_select(req.addr) == SEL_CFG0) begin
			next_cfg = cfg_t'((16'(cfg) & ~CFG0_WMASK)
				| (req.wdata[15:0] & CFG0_WMASK));
			next_cfg.sync = cfg.sync | req.wdata[CFG_SYNC_BIT];
		end

		// A reset in the same cycle as a clear still leaves the flag set.
		next_reset_complete = reset_complete_flag && !reset_complete_clear;
		next_irq_n = !(next_reset_complete || credit_irq);
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			soft_reset_out <= 1'b0;
		end else begin
			soft_reset_out <= next_soft_reset_out;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst_int) begin
			soft_reset_pending  <= 1'b0;
			cfg                 <= cfg_t'(CFG0_RESET);
			reset_complete_flag <= 1'b1;
			irq_n               <= 1'b0;
		end else begin
			soft_reset_pending  <= next_soft_reset_pending;
			cfg                 <= next_cfg;
			reset_complete_flag <= next_reset_complete;
			irq_n               <= next_irq_n;
		end
	end

	// ****************************************************************
	// Read path and flag outputs
	// ****************************************************************
	reg_resp_t next_resp;
	logic      next_min_chunk;

	always_comb begin
		next_resp.valid = req.rd;
		next_resp.data  = 32'h00000000;
		if (req.rd) begin
			unique case (reg_select(req.addr))
				SEL_CAP:   next_resp.data = CAPABILITY_VALUE;
				SEL_RESET: next_resp.data = 32'h00000000;
				SEL_CFG0:  next_resp.data = {16'h0000, 16'(cfg)};
				SEL_NONE:  next_resp.data = 32'h00000000;
			endcase
		end
		next_min_chunk = oa_mode;
	end

	always_ff @(posedge clk_sys) begin
		if (rst_int) begin
			resp                  <= '0;
			rx_footer_sync        <= 1'b0;
			tx_fcs_check_enable   <= 1'b0;
			min_chunk_payload_exp <= MIN_CHUNK_EXP;
		end else begin
			resp                  <= next_resp;
			rx_footer_sync        <= cfg.sync;
			tx_fcs_check_enable   <= cfg.tx_fcs_check_enable;
			min_chunk_payload_exp <= next_min_chunk ?
				CAPABILITY_VALUE[MIN_CHUNK_LSB +: 3] : 3'h0;
		end
	end

	rx_tx_policy u_policy (
		.clk_sys           (clk_sys),
		.rst               (rst_int),
		.oa_mode           (oa_mode),
		.cfg               (cfg),
		.tx_free_credits   (tx_free_credits),
		.start_word_offset (start_word_offset),
		.first_after_cs    (rx_chunk_first_after_cs),
		.credit_irq        (credit_irq),
		.rx_start_allowed  (rx_start_allowed)
	);

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);

	a_reset_deferred: assert property (soft_reset_pending && !cs_idle
		|=> !soft_reset_out)
		else $error("soft reset fired with chip select low");
	a_reset_fires: assert property (soft_reset_pending && cs_idle
		&& !soft_reset_out |=> soft_reset_out)
		else $error("soft reset did not fire after deselect");
	a_reset_defaults: assert property (soft_reset_out
		|=> 16'(cfg) == CFG0_RESET && !resp.valid)
		else $error("configuration not at default after reset");
	a_reset_selfclear: assert property (soft_reset_out
		|=> !soft_reset_pending ##1 !soft_reset_out)
		else $error("reset request did not clear itself");
	a_reset_status: assert property (soft_reset_out
		|=> reset_complete_flag && !irq_n && !cfg.sync)
		else $error("reset status not shown after reset");
	a_sync_sticky: assert property (cfg.sync && !rst_int
		|=> cfg.sync && rx_footer_sync)
		else $error("configuration flag lost without reset");
	a_sync_footer: assert property (req.wr && req.addr == ADDR_MACPHY_CONFIGURATION_0
		&& req.wdata[CFG_SYNC_BIT] && !rst_int ##1 !rst_int
		|=> rx_footer_sync)
		else $error("footer sync bit not following flag");
	a_cap_read: assert property (req.rd && req.addr == ADDR_CAPABILITY
		&& !rst_int |=> resp.valid && resp.data[2:0] == MIN_CHUNK_EXP)
		else $error("capability exponent wrong");
	a_reserved_zero: assert property (resp.valid
		|-> resp.data[31:16] == 16'h0000)
		else $error("reserved bits read non-zero");
	a_fcs_enable: assert property (req.wr && req.addr == ADDR_MACPHY_CONFIGURATION_0
		&& !rst_int ##1 !rst_int
		|=> tx_fcs_check_enable == $past(req.wdata[14], 2))
		else $error("FCS check enable not following write");

	c_soft_reset: cover property (soft_reset_pending ##1 soft_reset_out);
	c_sync_set: cover property (!cfg.sync ##1 cfg.sync);
	c_status_clear: cover property (reset_complete_flag
		##1 !reset_complete_flag);

endmodule

// [sim/spi_host_model.sv]
`timescale 1ns/10ps
module spi_host_model
	import macphy_cfg_pkg::*;
(
	input  wire logic clk_sys,  // System clock.
	output logic      cs_n_pin, // Chip select, active low.
	output reg_req_t  req       // Register access strobes.
);
	initial begin
		cs_n_pin = 1'b1;
		req = '0;
	end

	// One access: select, wait out the minimum hold, strobe, deselect unless keep_cs is set.
	// Address and data are inverted after use and both strobes cleared, so that nothing stale looks valid.
	task automatic access(input logic wr, input logic [7:0] addr,
		input logic [31:0] wdata, input logic keep_cs);
		@(negedge clk_sys);
		cs_n_pin = 1'b0;
		repeat (CS_MIN_HOLD_CYC) @(negedge clk_sys);
		// The host never turns on the MAC's own CRC append, so the
		// FCS check enable may be written at any time.
		req = {wr, !wr, addr, wdata};
		@(negedge clk_sys);
		req = {1'b0, 1'b0, ~addr, ~wdata};
		if (!keep_cs)
			cs_n_pin = 1'b1;
	endtask

	task automatic release_cs();
		@(negedge clk_sys);
		cs_n_pin = 1'b1;
	endtask
endmodule

// [sim/macphy_spi_config_reset_regs_bench.sv]
`timescale 1ns/10ps
module macphy_spi_config_reset_regs_bench
	import macphy_cfg_pkg::*;
;
	logic                clk_sys = 1'b0;
	logic                reset = 1'b1;
	logic                cs_n_pin;
	logic                oa_mode_pin = 1'b1;
	reg_req_t            req;
	logic                reset_complete_clear = 1'b0;
	logic [CREDIT_W-1:0] tx_free_credits = '0;
	logic [3:0]          start_word_offset = 4'h0;
	logic                rx_chunk_first_after_cs = 1'b0;
	reg_resp_t           resp;
	logic                soft_reset_out;
	logic                irq_n;
	logic                reset_complete_flag;
	logic                rx_footer_sync;
	logic                tx_fcs_check_enable;
	logic                rx_start_allowed;
	logic [2:0]          min_chunk_payload_exp;
	int                  miscompares = 0;
	int                  checks_done = 0;
	int                  seed = 75696;
	logic [31:0]         exp_q[$];

	always #20 clk_sys = ~clk_sys;

	spi_host_model spi_host_model_i (.clk_sys(clk_sys),
		.cs_n_pin(cs_n_pin), .req(req));

	macphy_cfg_regs macphy_cfg_regs_i (.clk_sys(clk_sys), .reset(reset),
		.cs_n_pin(cs_n_pin), .oa_mode_pin(oa_mode_pin), .req(req),
		.reset_complete_clear(reset_complete_clear),
		.tx_free_credits(tx_free_credits),
		.start_word_offset(start_word_offset),
		.rx_chunk_first_after_cs(rx_chunk_first_after_cs), .resp(resp),
		.soft_reset_out(soft_reset_out), .irq_n(irq_n),
		.reset_complete_flag(reset_complete_flag),
		.rx_footer_sync(rx_footer_sync),
		.tx_fcs_check_enable(tx_fcs_check_enable),
		.rx_start_allowed(rx_start_allowed),
		.min_chunk_payload_exp(min_chunk_payload_exp));

	task automatic cmp_read(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %0t: read %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_lvl(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %0t: output %h expected %h", $time, got, exp);
		end
	endtask

	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic rd(input logic [7:0] addr, input logic [31:0] exp);
		exp_q.push_back(exp);
		spi_host_model_i.access(1'b0, addr, 32'h00000000, 1'b0);
	endtask

	task automatic wr(input logic [7:0] addr, input logic [31:0] data);
		spi_host_model_i.access(1'b1, addr, data, 1'b0);
		repeat (3) @(negedge clk_sys);
	endtask

	// Read answers are matched in order against the noted expectations.
	always @(negedge clk_sys) begin
		if (resp.valid === 1'b1) begin
			if (exp_q.size() == 0)
				cmp_read(resp.data, ~resp.data);
			else
				cmp_read(resp.data, exp_q.pop_front());
		end
	end

	initial begin
		repeat (3000) @(negedge clk_sys);
		miscompares++;
		$display("Error %0t: timeout", $time);
		print_verdict();
	end

	initial begin
		int          i;
		int          j;
		logic [5:0]  thr[4];
		logic [7:0]  tab[7];
		thr = '{CREDITS_00, CREDITS_01, CREDITS_10, CREDITS_11};
		// {cs align, zero align, first chunk, offset, expected}.
		tab = '{8'hA1, 8'hB0, 8'hB4, 8'h44, 8'h41, 8'h0B, 8'h80};
		repeat (2) @(negedge clk_sys);
		reset = 1'b0;
		repeat (2) @(negedge clk_sys);
		cmp_lvl(reset_complete_flag, 1);
		cmp_lvl(irq_n, 0);
		cmp_lvl(min_chunk_payload_exp, 3);
		rd(ADDR_CAPABILITY, 32'h000006C3);
		rd(ADDR_MACPHY_CONFIGURATION_0, 32'h00000006);
		rd(ADDR_RESET_CTRL, 32'h00000000);
		rd(8'h10, 32'h00000000);
		wr(ADDR_MACPHY_CONFIGURATION_0, 32'hFFFFFFFF);
		cmp_lvl(rx_footer_sync, 1);
		cmp_lvl(tx_fcs_check_enable, 1);
		rd(ADDR_MACPHY_CONFIGURATION_0, 32'h0000FFDF);
		wr(ADDR_MACPHY_CONFIGURATION_0, 32'h00000000);
		rd(ADDR_MACPHY_CONFIGURATION_0, 32'h00008000);
		cmp_lvl(rx_footer_sync, 1);
		reset_complete_clear = 1'b1;
		@(negedge clk_sys);
		reset_complete_clear = 1'b0;
		for (i = 0; i < 4; i++) begin
			wr(ADDR_MACPHY_CONFIGURATION_0, 32'(i) << 10);
			for (j = 0; j < 3; j++) begin
				tx_free_credits = (j == 2) ? 6'($unsigned($random(seed)) % 20)
					: thr[i] - 6'(1 - j);
				repeat (3) @(negedge clk_sys);
				cmp_lvl(irq_n, tx_free_credits < thr[i]);
			end
		end
		for (i = 0; i < 7; i++) begin
			wr(ADDR_MACPHY_CONFIGURATION_0, 32'(tab[i][7:6]) << 12);
			rx_chunk_first_after_cs = tab[i][5];
			start_word_offset = tab[i][4:1];
			repeat (2) @(negedge clk_sys);
			cmp_lvl(rx_start_allowed, tab[i][0]);
		end
		oa_mode_pin = 1'b0;
		tx_free_credits = 6'h3F;
		repeat (5) @(negedge clk_sys);
		cmp_lvl(irq_n, 1);
		cmp_lvl(min_chunk_payload_exp, 0);
		cmp_lvl(rx_start_allowed, 1);
		oa_mode_pin = 1'b1;
		wr(ADDR_MACPHY_CONFIGURATION_0, 32'h00004000);
		cmp_lvl(tx_fcs_check_enable, 1);
		spi_host_model_i.access(1'b1, ADDR_RESET_CTRL, 32'h00000001, 1'b1);
		for (i = 0; i < 8; i++) begin
			@(negedge clk_sys);
			cmp_lvl(soft_reset_out, 0);
		end
		spi_host_model_i.release_cs();
		for (i = 0; i < 10 && soft_reset_out !== 1'b1; i++)
			@(negedge clk_sys);
		cmp_lvl(soft_reset_out, 1);
		@(negedge clk_sys);
		cmp_lvl(soft_reset_out, 0);
		cmp_lvl(rx_footer_sync, 0);
		cmp_lvl(reset_complete_flag, 1);
		cmp_lvl(irq_n, 0);
		cmp_lvl(tx_fcs_check_enable, 0);
		rd(ADDR_MACPHY_CONFIGURATION_0, 32'h00000006);
		rd(ADDR_RESET_CTRL, 32'h00000000);
		repeat (4) @(negedge clk_sys);
		cmp_lvl(exp_q.size(), 0);
		print_verdict();
	end
endmodule
